/* itb_core_model.sv */
/*
 * Behavioural model of the CPU core side: takes offered vectors, returns
 * from service on request and holds the stack-full level.
 * Assumes irq_req and irq_vector are registered on clk; sub clock runs free.
 */
module itb_core_model
    import itb_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       irq_req,
    input  wire logic [3:0] irq_vector,
    input  wire logic       hold_stack,
    input  wire logic       do_return_from_irq,
    input  wire logic [3:0] ack_delay,
    output logic            ack,
    output logic            ret_irq,
    output logic            stack_full,
    output logic            sub_clock,
    output logic [3:0]      taken_vec,
    output logic [7:0]      taken_cnt
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [3:0] wait_cnt;

    initial sub_clock = 1'b0;
    // Unrelated to ref_clk: 40 ns period, eight system cycles
    always #20 sub_clock = ~sub_clock;

    assign stack_full = hold_stack;

    // Any delay, 0 included, is safe: clearing the count while ack is high keeps a late-falling request from a second ack
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ack       <= 1'b0;
            wait_cnt  <= 4'h0;
            taken_vec <= VEC_NONE;
            taken_cnt <= 8'h00;
        end else begin
            ack <= 1'b0;
            if (!irq_req || ack) begin
                wait_cnt <= 4'h0;
            end else if (wait_cnt != ack_delay) begin
                wait_cnt <= wait_cnt + 4'h1;
            end else begin
                ack       <= 1'b1;
                taken_vec <= irq_vector;
                taken_cnt <= taken_cnt + 8'h01;
                wait_cnt  <= 4'h0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ret_irq <= 1'b0;
        end else begin
            ret_irq <= do_return_from_irq;
        end
    end
endmodule

/* itb_pkg.sv */
/*
 * Shared constants and types for the interrupt and time-base unit.
 * Assumes a single 200 MHz system clock domain and an Avalon-MM register slave.
 */
package itb_pkg;

    // ------------------------------------------------------------------
    // Register map (byte addresses, one 32-bit word each)
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_PSC_SEL  = 8'h00;
    localparam logic [7:0] ADDR_TB0_CTRL = 8'h04;
    localparam logic [7:0] ADDR_TB1_CTRL = 8'h08;
    localparam logic [7:0] ADDR_FLAGS    = 8'h0c;
    localparam logic [7:0] ADDR_ENABLES  = 8'h10;
    localparam logic [7:0] ADDR_GROUPS   = 8'h14;
    localparam logic [7:0] ADDR_CTRL     = 8'h18;
    localparam logic [7:0] ADDR_VECTOR   = 8'h1c;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int TB_ON_BIT     = 7;
    localparam int TB_CODE_W     = 3;
    localparam int PSC_SEL_W     = 2;
    localparam int TB_BASE_EXP   = 8;
    localparam int TB_CNT_W      = 16;
    localparam int GIE_BIT       = 0;
    localparam int STACK_FULL_BIT = 1;
    localparam int QDIV          = 4;

    // Flag vector layout (also enable vector layout)
    localparam int F_TB0   = 0;
    localparam int F_TB1   = 1;
    localparam int F_CONV  = 2;
    localparam int F_UART0 = 3;
    localparam int F_UART1 = 4;
    localparam int F_NVM   = 5;
    localparam int F_LVD   = 6;
    localparam int F_TM0A  = 7;
    localparam int F_TM0P  = 8;
    localparam int F_TM1A  = 9;
    localparam int F_TM1P  = 10;
    localparam int NFLAG   = 11;
    localparam int NGROUP  = 3;
    localparam int NVEC    = 8;

    localparam logic [7:0]       RST_BYTE  = 8'h00;
    localparam logic [NFLAG-1:0] RST_FLAGS = 11'h000;
    localparam logic [31:0]      RD_ZERO   = 32'h0000_0000;

    // Prescaler source encodings
    localparam logic [1:0] PSC_SYS  = 2'h0;
    localparam logic [1:0] PSC_DIV4 = 2'h1;

    // Vector numbers: direct sources then groups; fixed priority low first
    localparam logic [3:0] VEC_NONE = 4'hf;

    typedef struct packed {
        logic       on;
        logic [2:0] code;
    } itb_tb_cfg_t;

    typedef struct packed {
        logic       conv_done;
        logic [1:0] uart_evt;
        logic       nvm_done;
        logic       low_volt;
        logic [3:0] tm_match;
    } itb_events_t;

endpackage

/* itb_time_base.sv */
/*
 * One periodic time base: counts prescaler ticks, pulses on overflow.
 * Assumes tick is a single-cycle enable in the system clock domain.
 */
module itb_time_base
    import itb_pkg::*;
#(
    parameter int CNT_W = TB_CNT_W
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire itb_tb_cfg_t cfg,
    input  wire logic        tick,
    output logic             ovf
);
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] last_val;

    // Terminal count is 2^(8+code)-1
    assign last_val = CNT_W'((32'h1 << (TB_BASE_EXP + int'(cfg.code))) - 1);

    // ------------------------------------------------------------------
    // Divider
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= '0;
            ovf     <= 1'b0;
        end else if (!cfg.on) begin
            cnt_reg <= '0;
            ovf     <= 1'b0;
        end else if (tick) begin
            ovf <= (cnt_reg >= last_val);
            if (cnt_reg >= last_val) begin
                cnt_reg <= '0;
            end else begin
                cnt_reg <= cnt_reg + 1'b1;
            end
        end else begin
            ovf <= 1'b0;
        end
    end
endmodule

/* itb_top.sv */
/*
 * Interrupt request flags, grouping, vectoring and two time bases.
 * Assumes the CPU core pulses ack when it takes the offered vector and
 * pulses ret_irq on a return-from-interrupt; peripheral events are
 * one-cycle pulses on ref_clk; sub_clock is an asynchronous pin.
 */
// Our own choices: register access over Avalon-MM and the register offsets.
// Operation
// - Prescaler source: sys, sys/4, sub clock
// - Time base 0 period 2^(8+code)
// - Time base 1 same as time base 0
// - Unimplemented bits zero, reset to zero
// - Converter flag sets on conversion done
// - Converter vectors with both enables; auto-clear
// - Any UART event raises its flag
// - UART service clears flag, not status
// - Three groups of timer, nvm, low-volt
// - Member flag sets group; enabled vectors
// - Group service clears only group flag
// - Nvm flag on write end, stays set
// - Low-volt flag on detection, stays set
// - Two match flags per timer, grouped
// - No vector while stack full
// - Any flag rising wakes the core; here only source flags wake it, group flags do not
// - Time-base overflow sets its flag
// - Return-from-interrupt sets global enable
module itb_top
    import itb_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        rstn,
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    output logic [1:0]       avs_response,
    input  wire logic        sub_clock,
    input  wire itb_events_t events,
    input  wire logic        stack_full,
    input  wire logic        ack,
    input  wire logic        ret_irq,
    output logic             irq_req,
    output logic [3:0]       irq_vector,
    output logic             wake_up
);
    logic [1:0]       rst_sync;
    logic             rst_n;
    logic [1:0]       psc_sel_reg;
    itb_tb_cfg_t      tb0_cfg_reg;
    itb_tb_cfg_t      tb1_cfg_reg;
    logic [NFLAG-1:0] flag_reg;
    logic [NFLAG-1:0] en_reg;
    logic [NGROUP-1:0] grp_flag_reg;
    logic [NGROUP-1:0] grp_en_reg;
    logic             gie_reg;
    logic [2:0]       sub_sync;
    logic             sub_lvl_reg;
    logic [1:0]       div4_reg;
    logic             tick;
    logic             tb0_ovf;
    logic             tb1_ovf;
    logic [NFLAG-1:0] set_vec;
    logic [NFLAG-1:0] clr_vec;
    logic [NGROUP-1:0] grp_set;
    logic [NGROUP-1:0] grp_clr;
    logic [3:0]       pick;
    logic [NVEC-1:0]  pend;
    logic             wr_acc;
    logic             rd_acc;
    logic             ack_take;

    import itb_pkg::*;

    // ------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    // ------------------------------------------------------------------
    // Prescaler clock
    // ------------------------------------------------------------------
    // Sub clock is sampled as data; a new level counts once stages 2 and 3 agree
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sub_sync    <= 3'h0;
            sub_lvl_reg <= 1'b0;
            div4_reg    <= 2'h0;
        end else begin
            sub_sync <= {sub_sync[1:0], sub_clock};
            div4_reg <= div4_reg + 2'h1;
            if (sub_sync[2] == sub_sync[1]) begin
                sub_lvl_reg <= sub_sync[2];
            end
        end
    end

    always_comb begin
        if (psc_sel_reg == PSC_SYS) begin
            tick = 1'b1;
        end else if (psc_sel_reg == PSC_DIV4) begin
            tick = (div4_reg == 2'(QDIV - 1));
        end else begin
            tick = (sub_sync[2:1] == 2'h3) & ~sub_lvl_reg;
        end
    end

    itb_time_base u_tb0 (
        .clk  (ref_clk),
        .rst_n(rst_n),
        .cfg  (tb0_cfg_reg),
        .tick (tick),
        .ovf  (tb0_ovf)
    );

    itb_time_base u_tb1 (
        .clk  (ref_clk),
        .rst_n(rst_n),
        .cfg  (tb1_cfg_reg),
        .tick (tick),
        .ovf  (tb1_ovf)
    );

    // ------------------------------------------------------------------
    // Bus slave: one cycle of wait, answer on the second edge
    // ------------------------------------------------------------------
    assign wr_acc = avs_write & ~avs_waitrequest;
    assign rd_acc = avs_read & ~avs_waitrequest;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            avs_readdata <= RD_ZERO;
            avs_response <= 2'h0;
        end else if ((avs_read | avs_write) & avs_waitrequest) begin
            avs_response <= 2'h0;
            avs_readdata <= RD_ZERO;
            if (avs_address == ADDR_PSC_SEL) begin
                avs_readdata <= {30'h0, psc_sel_reg};
            end else if (avs_address == ADDR_TB0_CTRL) begin
                avs_readdata <= {24'h0, tb0_cfg_reg.on, 4'h0, tb0_cfg_reg.code};
            end else if (avs_address == ADDR_TB1_CTRL) begin
                avs_readdata <= {24'h0, tb1_cfg_reg.on, 4'h0, tb1_cfg_reg.code};
            end else if (avs_address == ADDR_FLAGS) begin
                avs_readdata <= {21'h0, flag_reg};
            end else if (avs_address == ADDR_ENABLES) begin
                avs_readdata <= {21'h0, en_reg};
            end else if (avs_address == ADDR_GROUPS) begin
                avs_readdata <= {21'h0, grp_en_reg, 5'h0, grp_flag_reg};
            end else if (avs_address == ADDR_CTRL) begin
                avs_readdata <= {30'h0, stack_full, gie_reg};
            end else if (avs_address == ADDR_VECTOR) begin
                avs_readdata <= {27'h0, irq_req, irq_vector};
            end else begin
                avs_response <= 2'h2;
            end
        end
    end

    // ------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            psc_sel_reg <= 2'h0;
            tb0_cfg_reg <= '0;
            tb1_cfg_reg <= '0;
            en_reg      <= RST_FLAGS;
            grp_en_reg  <= 3'h0;
        end else if (wr_acc & avs_byteenable[0]) begin
            if (avs_address == ADDR_PSC_SEL) begin
                psc_sel_reg <= avs_writedata[PSC_SEL_W-1:0];
            end else if (avs_address == ADDR_TB0_CTRL) begin
                tb0_cfg_reg <= {avs_writedata[TB_ON_BIT], avs_writedata[TB_CODE_W-1:0]};
            end else if (avs_address == ADDR_TB1_CTRL) begin
                tb1_cfg_reg <= {avs_writedata[TB_ON_BIT], avs_writedata[TB_CODE_W-1:0]};
            end else if (avs_address == ADDR_ENABLES) begin
                en_reg <= avs_writedata[NFLAG-1:0];
            end else if (avs_address == ADDR_GROUPS) begin
                grp_en_reg <= avs_writedata[NFLAG-1:8];
            end
        end
    end

    // ------------------------------------------------------------------
    // Source flags: hardware set beats software clear
    // ------------------------------------------------------------------
    assign set_vec = {events.tm_match, events.low_volt, events.nvm_done,
                      events.uart_evt, events.conv_done, tb1_ovf, tb0_ovf};

    always_comb begin
        clr_vec = '0;
        if (wr_acc & avs_byteenable[0] & (avs_address == ADDR_FLAGS)) begin
            clr_vec = avs_writedata[NFLAG-1:0];
        end
        // Direct sources clear on their own service; grouped ones never do
        if (ack_take & (pick < 4'(F_NVM))) begin
            clr_vec[pick] = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            flag_reg <= RST_FLAGS;
        end else begin
            flag_reg <= set_vec | (flag_reg & ~clr_vec);
        end
    end

    // ------------------------------------------------------------------
    // Groups: 0 = nvm+lvd, 1 = timer 0, 2 = timer 1
    // ------------------------------------------------------------------
    generate
        for (genvar g = 0; g < NGROUP; g++) begin : g_grp
            logic [1:0] mem;
            assign mem = (g == 0) ? {set_vec[F_LVD] & en_reg[F_LVD],
                                     set_vec[F_NVM] & en_reg[F_NVM]}
                       : {set_vec[F_TM0P + 2*(g-1)] & en_reg[F_TM0P + 2*(g-1)],
                          set_vec[F_TM0A + 2*(g-1)] & en_reg[F_TM0A + 2*(g-1)]};
            assign grp_set[g] = |mem;
            assign grp_clr[g] = ack_take & (pick == 4'(F_NVM + g));
        end
    endgenerate

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            grp_flag_reg <= 3'h0;
        end else begin
            grp_flag_reg <= grp_set | (grp_flag_reg & ~grp_clr);
            if (wr_acc & avs_byteenable[0] & (avs_address == ADDR_GROUPS)) begin
                grp_flag_reg <= grp_set | (grp_flag_reg & ~grp_clr
                                & ~avs_writedata[NGROUP-1:0]);
            end
        end
    end

    // ------------------------------------------------------------------
    // Vectoring: index 0..4 direct sources, 5..7 groups
    // ------------------------------------------------------------------
    assign pend = {grp_flag_reg & grp_en_reg, flag_reg[F_UART1:F_TB0] & en_reg[F_UART1:F_TB0]};
    assign ack_take = ack & irq_req;

    always_comb begin
        pick = VEC_NONE;
        for (int i = NVEC - 1; i >= 0; i--) begin
            if (pend[i]) begin
                pick = 4'(i);
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_req    <= 1'b0;
            irq_vector <= VEC_NONE;
        end else begin
            irq_req    <= gie_reg & ~stack_full & (pick != VEC_NONE) & ~ack_take;
            irq_vector <= pick;
        end
    end

    // Set on return beats software write; service clears
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            gie_reg <= 1'b0;
        end else if (ret_irq) begin
            gie_reg <= 1'b1;
        end else if (ack_take) begin
            gie_reg <= 1'b0;
        end else if (wr_acc & avs_byteenable[0] & (avs_address == ADDR_CTRL)) begin
            gie_reg <= avs_writedata[GIE_BIT];
        end
    end

    // ------------------------------------------------------------------
    // Wake-up on any rising source flag (group flags not included), enables ignored
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wake_up <= 1'b0;
        end else begin
            wake_up <= |(set_vec & ~flag_reg);
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    no_vec_full_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        stack_full |=> !irq_req) else $error("vector offered with stack full");
    gie_ack_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ack_take && !ret_irq |=> !gie_reg) else $error("global enable kept after service");
    return_from_irq_set_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ret_irq |=> gie_reg) else $error("return did not set global enable");
    conv_set_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        events.conv_done |=> flag_reg[F_CONV]) else $error("converter flag not set");
    tb0_flag_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        tb0_ovf |=> flag_reg[F_TB0]) else $error("time base flag not set");
    nvm_keep_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ack_take && pick == 4'(F_NVM) && flag_reg[F_NVM] |=> flag_reg[F_NVM])
        else $error("nvm flag cleared by service");
    lvd_keep_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        flag_reg[F_LVD] && !wr_acc |=> flag_reg[F_LVD]) else $error("low-volt flag lost");
    wake_rise_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        events.low_volt && !flag_reg[F_LVD] |=> wake_up) else $error("no wake-up");
    grp_set_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        events.nvm_done && en_reg[F_NVM] |=> grp_flag_reg[0]) else $error("group flag not set");
    psc_rd_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        avs_read && avs_waitrequest && avs_address == ADDR_PSC_SEL |=> avs_readdata[31:2] == 30'h0)
        else $error("reserved bits nonzero");
    cover_vec_c: cover property (@(posedge ref_clk) disable iff (!rst_n) ack_take);
    cover_grp_c: cover property (@(posedge ref_clk) disable iff (!rst_n) grp_clr != 3'h0);
    cover_wake_c: cover property (@(posedge ref_clk) disable iff (!rst_n) wake_up);
endmodule

/* tb_itb_top.sv */
/*
 * Self-checking bench for the interrupt and time-base unit.
 * Assumes the core model answers vectors and events are one-cycle pulses.
 */
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
    $display("Error t=%0t got %h exp %h", $time, (g), (e)); end end

module tb_itb_top
    import itb_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic        ref_clk = 1'b0;
    logic        rstn = 1'b0;
    logic [7:0]  avs_address = 8'h00;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [1:0]  avs_response;
    logic        sub_clock;
    itb_events_t events = '0;
    logic        stack_full;
    logic        ack;
    logic        ret_irq;
    logic        irq_req;
    logic        wake_up;
    logic [3:0]  irq_vector;
    logic [3:0]  taken_vec;
    logic [7:0]  taken_cnt;
    logic        hold_stack = 1'b0;
    logic        do_return_from_irq = 1'b0;
    logic [3:0]  ack_delay = 4'h2;
    logic [31:0] rdata;
    logic [1:0]  resp;
    int          n_errors = 0;
    int          n_compared = 0;
    int          n_wake = 0;
    int          cyc = 0;
    int          wake_cyc = 0;

    itb_top itb_top_inst (.ref_clk(ref_clk), .rstn(rstn), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
        .sub_clock(sub_clock), .events(events), .stack_full(stack_full), .ack(ack),
        .ret_irq(ret_irq), .irq_req(irq_req), .irq_vector(irq_vector), .wake_up(wake_up));

    itb_core_model itb_core_model_inst (.clk(ref_clk), .rst_n(rstn), .irq_req(irq_req),
        .irq_vector(irq_vector), .hold_stack(hold_stack), .do_return_from_irq(do_return_from_irq),
        .ack_delay(ack_delay), .ack(ack), .ret_irq(ret_irq), .stack_full(stack_full),
        .sub_clock(sub_clock), .taken_vec(taken_vec), .taken_cnt(taken_cnt));

    always #2.5 ref_clk = ~ref_clk;

    // Wake pulses last one cycle, so they are counted rather than polled
    always @(posedge ref_clk) begin
        cyc++;
        if (wake_up === 1'b1) begin
            n_wake++;
            wake_cyc = cyc;
        end
    end

    // ------------------------------------------------------------------
    // Bus and helper tasks
    // ------------------------------------------------------------------
    task bus(input logic wr_n_rd, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge ref_clk);
        avs_address   <= a;
        avs_write     <= wr_n_rd;
        avs_read      <= !wr_n_rd;
        avs_writedata <= d;
        k = 0;
        do begin
            @(posedge ref_clk);
            k++;
        end while (avs_waitrequest !== 1'b0 && k < 50);
        rdata = avs_readdata;
        resp  = avs_response;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        if (k >= 50) n_errors++;
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task rdr(input logic [7:0] a);
        bus(1'b0, a, 32'h0000_0000);
    endtask

    task wait_wake(input int w0);
        int k;
        k = 0;
        while (n_wake == w0 && k < 6000) begin
            @(posedge ref_clk);
            k++;
        end
        if (k >= 6000) n_errors++;
    endtask

    task wait_taken(input logic [7:0] c0);
        int k;
        k = 0;
        while (taken_cnt === c0 && k < 100) begin
            @(posedge ref_clk);
            k++;
        end
        if (k >= 100) n_errors++;
    endtask

    task pulse(input int k);
        @(posedge ref_clk);
        events <= itb_events_t'(9'h001 << k);
        @(posedge ref_clk);
        events <= '0;
    endtask

    task return_from_irq;
        @(posedge ref_clk);
        do_return_from_irq <= 1'b1;
        @(posedge ref_clk);
        do_return_from_irq <= 1'b0;
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task t_regs;
        rdr(ADDR_PSC_SEL);
        `CHK(rdata, RD_ZERO)
        rdr(ADDR_TB0_CTRL);
        `CHK(rdata, RD_ZERO)
        rdr(ADDR_TB1_CTRL);
        `CHK(rdata, RD_ZERO)
        wr(ADDR_PSC_SEL, 32'hffff_ffff);
        rdr(ADDR_PSC_SEL);
        `CHK(rdata, 32'h0000_0003)
        wr(ADDR_TB0_CTRL, 32'hffff_ffff);
        rdr(ADDR_TB0_CTRL);
        `CHK(rdata, 32'h0000_0087)
        wr(ADDR_TB1_CTRL, 32'hffff_ffff);
        rdr(ADDR_TB1_CTRL);
        `CHK(rdata, 32'h0000_0087)
        wr(ADDR_TB0_CTRL, RD_ZERO);
        wr(ADDR_TB1_CTRL, RD_ZERO);
        wr(ADDR_PSC_SEL, RD_ZERO);
        wr(ADDR_FLAGS, 32'h0000_0003);
        rdr(8'h40);
        `CHK(rdata, RD_ZERO)
        `CHK(resp, 2'h2)
    endtask

    // Interval between two overflows, flag cleared in between
    task t_period(input logic [1:0] sel, input logic [7:0] a, input int code,
                  input int fbit, input int mult, input int tol);
        int w;
        int c1;
        int dt;
        int expc;
        expc = (1 << (TB_BASE_EXP + code)) * mult;
        wr(ADDR_PSC_SEL, {30'h0, sel});
        wr(a, 32'h0000_0080 | code);
        w = n_wake;
        wait_wake(w);
        c1 = wake_cyc;
        wr(ADDR_FLAGS, 32'h1 << fbit);
        w = n_wake;
        wait_wake(w);
        dt = wake_cyc - c1;
        `CHK(dt >= expc - tol && dt <= expc + tol, 1'b1)
        wr(a, RD_ZERO);
        wr(ADDR_FLAGS, 32'h1 << fbit);
    endtask

    task automatic t_sources;
        int ev[9] = '{8, 6, 7, 5, 4, 0, 1, 2, 3};
        int fb[9] = '{F_CONV, F_UART0, F_UART1, F_NVM, F_LVD, F_TM0A, F_TM0P, F_TM1A, F_TM1P};
        logic [3:0] vec[9] = '{4'h2, 4'h3, 4'h4, 4'h5, 4'h5, 4'h6, 4'h6, 4'h7, 4'h7};
        int w;
        logic [7:0] c;
        wr(ADDR_ENABLES, 32'h0000_07fc);
        wr(ADDR_GROUPS, 32'h0000_0700);
        wr(ADDR_CTRL, 32'h0000_0001);
        for (int i = 0; i < 9; i++) begin
            w = n_wake;
            c = taken_cnt;
            pulse(ev[i]);
            wait_taken(c);
            `CHK(taken_vec, vec[i])
            `CHK(n_wake != w, 1'b1)
            rdr(ADDR_FLAGS);
            `CHK(rdata[fb[i]], logic'(i >= 3))
            rdr(ADDR_GROUPS);
            `CHK(rdata, 32'h0000_0700)
            rdr(ADDR_CTRL);
            `CHK(rdata, RD_ZERO)
            wr(ADDR_FLAGS, 32'h1 << fb[i]);
            return_from_irq;
            rdr(ADDR_CTRL);
            `CHK(rdata[GIE_BIT], 1'b1)
        end
    endtask

    task t_stack_prio;
        logic [7:0] c;
        c = taken_cnt;
        hold_stack <= 1'b1;
        ack_delay  <= 4'ha;
        pulse(6);
        pulse(8);
        repeat (20) @(posedge ref_clk);
        `CHK(irq_req, 1'b0)
        rdr(ADDR_FLAGS);
        `CHK(rdata[F_CONV] & rdata[F_UART0], 1'b1)
        hold_stack <= 1'b0;
        wait_taken(c);
        `CHK(taken_vec, 4'h2)
        repeat (30) @(posedge ref_clk);
        `CHK(taken_cnt, c + 8'h01)
        return_from_irq;
        wait_taken(c + 8'h01);
        `CHK(taken_vec, 4'h3)
        return_from_irq;
        ack_delay <= 4'h2;
    endtask

    task t_wake;
        int w;
        wr(ADDR_ENABLES, RD_ZERO);
        wr(ADDR_CTRL, RD_ZERO);
        w = n_wake;
        pulse(4);
        repeat (6) @(posedge ref_clk);
        `CHK(n_wake, w + 1)
        pulse(4);
        repeat (6) @(posedge ref_clk);
        `CHK(n_wake, w + 1)
        rdr(ADDR_FLAGS);
        `CHK(rdata[F_LVD], 1'b1)
        wr(ADDR_FLAGS, 32'h1 << F_LVD);
        rdr(ADDR_FLAGS);
        `CHK(rdata, RD_ZERO)
    endtask

    task complete_run;
        $display("Compared %0d, errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        repeat (3) @(posedge ref_clk);
        rstn <= 1'b1;
        repeat (5) @(posedge ref_clk);
        t_regs();
        t_period(PSC_SYS, ADDR_TB0_CTRL, 0, F_TB0, 1, 0);
        t_period(PSC_DIV4, ADDR_TB1_CTRL, 1, F_TB1, QDIV, 0);
        t_period(2'h2, ADDR_TB0_CTRL, 0, F_TB0, 8, 1);
        t_period(2'h3, ADDR_TB1_CTRL, 0, F_TB1, 8, 1);
        t_sources();
        t_stack_prio();
        t_wake();
        complete_run();
    end

    // Whole run is near 13000 cycles; this leaves a wide margin
    initial begin
        #400us;
        n_errors++;
        complete_run();
    end
endmodule
